// *** bench/host_request_model.sv ***
// Host side model issuing set-feature requests
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module host_request_model (
  input wire logic clk_in,
  input wire logic req_done_in,
  input wire logic req_stall_in,
  output logic req_valid_out,
  output logic [15:0] req_selector_out,
  output logic [15:0] req_index_out,
  output logic [15:0] req_length_out
);
  initial begin
    req_valid_out = 1'b0;
    req_selector_out = 16'h0000;
    req_index_out = 16'h0000;
    req_length_out = 16'h0000;
  end
  task automatic send(input logic [15:0] sel, input logic [7:0] val, input logic [7:0] port,
    input logic [15:0] len, output logic done, output logic stall);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_selector_out <= sel;
    req_index_out <= {val, port};
    req_length_out <= len;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_selector_out <= ~sel;
    req_index_out <= ~{val, port};
    req_length_out <= ~len;
    #1;
    done = req_done_in;
    stall = req_stall_in;
  endtask
  task automatic set_mask(input logic [2:0] mask, input logic [7:0] port, output logic stall);
    logic done;
    send(`SEL_WAKE_MASK, {5'h00, mask}, port, 16'h0000, done, stall);
  endtask
endmodule

// *** bench/hub_port_set_feature_handler_properties.sv ***
// Concurrent checks on the set-feature handler ports
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module hub_feature_checker
  import hub_feature_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire logic [15:0] req_selector_in,
  input wire logic [15:0] req_index_in,
  input wire logic [15:0] req_length_in,
  input wire logic req_done_out,
  input wire logic req_stall_out,
  input port_vec_t port_powered_in,
  input port_vec_t port_enabled_in,
  input port_vec_t port_suspended_in,
  input port_vec_t connect_event_in,
  input port_vec_t disconnect_event_in,
  input port_vec_t oc_event_in,
  input port_vec_t reset_done_in,
  input port_vec_t port_reset_start_out,
  input port_vec_t warm_reset_start_out,
  input port_vec_t reset_finish_out,
  input port_vec_t power_on_out,
  input port_vec_t u3_request_out,
  input port_vec_t force_lpm_out,
  input port_vec_t warm_change_out,
  input wire logic remote_wake_out
);
  port_vec_t tgt;
  port_vec_t ev_susp;
  assign tgt = (req_index_in[7:0] != 8'h00 && req_index_in[7:0] <= `NPORTS) ? 4'h1 << (req_index_in[2:0] - 3'h1) : 4'h0;
  assign ev_susp = (connect_event_in | disconnect_event_in | oc_event_in) & port_suspended_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  AST_ERR_STALL: assert property (req_valid_in && (tgt == 4'h0 || req_length_in != 16'h0000)
    |=> req_done_out && req_stall_out) else $error("bad request not stalled");
  AST_RESET_OFF: assert property (req_valid_in && req_selector_in == `SEL_PORT_RESET
    && (tgt & port_powered_in) == 4'h0 |=> port_reset_start_out == 4'h0) else $error("reset on unpowered port");
  AST_U3_IDLE: assert property (req_valid_in && req_selector_in == `SEL_LINK_STATE
    && req_index_in[15:8] == `LINK_U3 && (tgt & port_enabled_in) == 4'h0 |=> u3_request_out == 4'h0)
    else $error("U3 on port not enabled");
  AST_POWER_IDLE: assert property (req_valid_in && req_selector_in == `SEL_PORT_POWER
    && (tgt & port_powered_in) != 4'h0 |=> power_on_out == 4'h0) else $error("power on powered port");
  AST_LPM_IDLE: assert property (req_valid_in && req_selector_in == `SEL_FORCE_LPM
    && (tgt & port_enabled_in) == 4'h0 |=> force_lpm_out == 4'h0) else $error("lpm on port not enabled");
  AST_WARM_START: assert property (req_valid_in && req_selector_in == `SEL_BH_RESET
    |=> req_stall_out || warm_reset_start_out == $past(tgt)) else $error("warm reset start wrong");
  AST_FINISH_CAUSE: assert property (reset_finish_out != 4'h0
    |-> (reset_finish_out & ~$past(reset_done_in)) == 4'h0) else $error("finish without link done");
  AST_WARM_FLAG: assert property ((warm_change_out & ~$past(warm_change_out)) != 4'h0
    |-> (warm_change_out & ~$past(warm_change_out) & ~reset_finish_out) == 4'h0) else $error("warm flag rose alone");
  AST_WAKE_CAUSE: assert property (remote_wake_out |-> $past(ev_susp, 2) != 4'h0)
    else $error("wake without suspended event");
  COV_STALL: cover property (req_valid_in ##1 req_stall_out);
  COV_WARM: cover property (warm_change_out != 4'h0);
  COV_WAKE: cover property (remote_wake_out);
endmodule

// *** bench/hub_port_set_feature_handler_tb.sv ***
// Self-checking testbench for the set-feature handler
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module hub_port_set_feature_handler_tb;
  import hub_feature_pkg::*;
  logic clk_in, arst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
  logic req_valid_in, req_done_out, req_stall_out, remote_wake_out, irq_out, done, stall, hub_oc_event_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic [15:0] req_selector_in, req_index_in, req_length_in;
  port_vec_t port_powered_in, port_enabled_in, port_suspended_in, connect_event_in, disconnect_event_in;
  port_vec_t oc_event_in, reset_done_in, port_reset_start_out, warm_reset_start_out, reset_finish_out;
  port_vec_t power_on_out, u3_request_out, force_lpm_out, warm_change_out;
  int bad_count, checks_done;
  hub_port_set_feature_handler uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .req_valid_in(req_valid_in), .req_selector_in(req_selector_in),
    .req_index_in(req_index_in), .req_length_in(req_length_in), .req_done_out(req_done_out),
    .req_stall_out(req_stall_out), .port_powered_in(port_powered_in), .port_enabled_in(port_enabled_in),
    .port_suspended_in(port_suspended_in), .connect_event_in(connect_event_in),
    .disconnect_event_in(disconnect_event_in), .oc_event_in(oc_event_in), .hub_oc_event_in(hub_oc_event_in),
    .reset_done_in(reset_done_in), .port_reset_start_out(port_reset_start_out),
    .warm_reset_start_out(warm_reset_start_out), .reset_finish_out(reset_finish_out),
    .power_on_out(power_on_out), .u3_request_out(u3_request_out), .force_lpm_out(force_lpm_out),
    .warm_change_out(warm_change_out), .remote_wake_out(remote_wake_out), .irq_out(irq_out));
  host_request_model host (.clk_in(clk_in), .req_done_in(req_done_out), .req_stall_in(req_stall_out),
    .req_valid_out(req_valid_in), .req_selector_out(req_selector_in), .req_index_out(req_index_in),
    .req_length_out(req_length_in));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    haddr_in <= {24'h000000, a};
    wait_ready();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_ready();
    rdat = hrdata_out;
    hsel_in <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    check(what, rd, exp);
    check("okay response", hresp_out, 32'h0);
  endtask
  task automatic t_reset();
    rd_chk("wake mask after reset", `REG_WAKE_MASK, 32'h0);
    host.send(`SEL_PORT_POWER, 8'h00, 8'h01, 16'h0000, done, stall);
    check("unconfigured stall", stall, 32'h1);
    bus(1'b1, `REG_CTRL, 32'h1, rd);
    bus(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    rd_chk("unmapped read", 8'h40, 32'h0);
    rd_chk("ctrl configured", `REG_CTRL, 32'h1);
  endtask
  task automatic t_errors();
    logic [15:0] sel [5] = '{16'h0009, 16'h00FF, `SEL_PORT_POWER, `SEL_PORT_POWER, `SEL_PORT_POWER};
    logic [7:0] prt [5] = '{8'h01, 8'h01, 8'h00, 8'h05, 8'h01};
    logic [15:0] len [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    for (int i = 0; i < 5; i++) begin
      host.send(sel[i], 8'h00, prt[i], len[i], done, stall);
      check("error done", done, 32'h1);
      check("error stall", stall, 32'h1);
    end
    host.send(`SEL_U1_TIMEOUT, 8'h05, 8'h04, 16'h0000, done, stall);
    check("good request stall", stall, 32'h0);
  endtask
  task automatic t_mask();
    logic [2:0] m [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    for (int p = 1; p <= 4; p++) begin
      host.set_mask(m[p-1], p[7:0], stall);
      check("mask stall", stall, 32'h0);
    end
    rd_chk("wake masks", `REG_WAKE_MASK, 32'h07040201);
  endtask
  task automatic act(input logic [15:0] sel, input logic [7:0] val, input logic pw, input logic en,
    input logic [3:0] exp);
    @(posedge clk_in);
    port_powered_in <= {2'h0, pw, 1'b0};
    port_enabled_in <= {2'h0, en, 1'b0};
    host.send(sel, val, 8'h02, 16'h0000, done, stall);
    check("action pulses", port_reset_start_out | power_on_out | u3_request_out | force_lpm_out, exp);
  endtask
  task automatic t_noops();
    act(`SEL_PORT_RESET, 8'h00, 1'b0, 1'b0, 4'h0);
    act(`SEL_PORT_RESET, 8'h00, 1'b1, 1'b0, 4'h2);
    act(`SEL_PORT_POWER, 8'h00, 1'b1, 1'b1, 4'h0);
    act(`SEL_PORT_POWER, 8'h00, 1'b0, 1'b0, 4'h2);
    act(`SEL_LINK_STATE, `LINK_U3, 1'b1, 1'b0, 4'h0);
    act(`SEL_LINK_STATE, `LINK_U3, 1'b1, 1'b1, 4'h2);
    act(`SEL_FORCE_LPM, 8'h00, 1'b1, 1'b0, 4'h0);
    act(`SEL_FORCE_LPM, 8'h00, 1'b1, 1'b1, 4'h2);
  endtask
  task automatic t_warm();
    host.send(`SEL_BH_RESET, 8'h00, 8'h03, 16'h0000, done, stall);
    check("warm start", warm_reset_start_out, 32'h4);
    @(posedge clk_in);
    reset_done_in <= 4'h6;
    @(posedge clk_in);
    reset_done_in <= 4'h0;
    #1;
    check("finish both kinds", reset_finish_out, 32'h6);
    check("warm change", warm_change_out, 32'h4);
    rd_chk("irq status", `REG_IRQ_STATUS, 32'h3);
    check("irq masked", irq_out, 32'h0);
    bus(1'b1, `REG_IRQ_MASK, 32'h2, rd);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq raised", irq_out, 32'h1);
    bus(1'b1, `REG_IRQ_STATUS, 32'h3, rd);
    bus(1'b1, `REG_PORT_CHANGE, 32'hF00, rd);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq cleared", irq_out, 32'h0);
    check("warm change cleared", warm_change_out, 32'h0);
  endtask
  task automatic ev(input logic [1:0] kind, input logic [3:0] bits, input logic exp);
    @(posedge clk_in);
    connect_event_in <= (kind == 2'h0) ? bits : 4'h0;
    disconnect_event_in <= (kind == 2'h1) ? bits : 4'h0;
    oc_event_in <= (kind == 2'h2) ? bits : 4'h0;
    hub_oc_event_in <= (kind == 2'h3);
    @(posedge clk_in);
    connect_event_in <= 4'h0;
    disconnect_event_in <= 4'h0;
    oc_event_in <= 4'h0;
    hub_oc_event_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1;
      check("wake pulse", remote_wake_out, {31'h0, exp && (i == 0)});
    end
  endtask
  task automatic t_wake();
    @(posedge clk_in);
    port_suspended_in <= 4'hF;
    ev(2'h0, 4'h1, 1'b1);
    ev(2'h0, 4'h2, 1'b0);
    ev(2'h1, 4'h2, 1'b1);
    ev(2'h1, 4'h1, 1'b0);
    ev(2'h2, 4'h1, 1'b0);
    ev(2'h2, 4'h4, 1'b1);
    ev(2'h3, 4'h0, 1'b0);
    rd_chk("change flags", `REG_PORT_CHANGE, 32'h00000053);
  endtask
  initial begin
    arst_n_in = 1'b0;
    {hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
    hsize_in = 3'h2;
    {port_powered_in, port_enabled_in, port_suspended_in, reset_done_in} = '0;
    {hub_oc_event_in, connect_event_in, disconnect_event_in, oc_event_in} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_errors();
    t_mask();
    t_noops();
    t_warm();
    t_wake();
    final_report();
  end
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
bind hub_port_set_feature_handler hub_feature_checker chk (.clk_in, .arst_n_in, .req_valid_in, .req_selector_in,
  .req_index_in, .req_length_in, .req_done_out, .req_stall_out, .port_powered_in, .port_enabled_in,
  .port_suspended_in, .connect_event_in, .disconnect_event_in, .oc_event_in, .reset_done_in,
  .port_reset_start_out, .warm_reset_start_out, .reset_finish_out, .power_on_out, .u3_request_out,
  .force_lpm_out, .warm_change_out, .remote_wake_out);

// *** core/ahb_reg_port.sv ***
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module ahb_reg_port (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] rd_data_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output hub_feature_pkg::reg_addr_t rd_addr_out,
  output logic wr_en_out,
  output hub_feature_pkg::reg_addr_t wr_addr_out,
  output logic [31:0] wr_data_out
);
  import hub_feature_pkg::*;
  logic addr_phase;
  logic wr_pending;
  reg_addr_t wr_addr;
  assign addr_phase = hsel_in && htrans_in[1] && hready_in && (hsize_in == 3'h2);
  assign rd_addr_out = haddr_in[7:0];
  assign wr_en_out = wr_pending;
  assign wr_addr_out = wr_addr;
  assign wr_data_out = hwdata_in;
  // Address phase capture
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= addr_phase && hwrite_in;
      if (addr_phase) begin
        wr_addr <= haddr_in[7:0];
      end
    end
  end
  // Read data registered at address phase
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (addr_phase && !hwrite_in) begin
        hrdata_out <= rd_data_in;
      end
    end
  end
endmodule

// *** core/hub_feature_params.svh ***
// Constants for the downstream port set-feature handler
`ifndef HUB_FEATURE_PARAMS_SVH
`define HUB_FEATURE_PARAMS_SVH
`define NPORTS 4
`define PER_PORT_OC 1'b1
`define SEL_PORT_RESET 16'h0001
`define SEL_PORT_POWER 16'h0002
`define SEL_LINK_STATE 16'h0003
`define SEL_U1_TIMEOUT 16'h0004
`define SEL_U2_TIMEOUT 16'h0005
`define SEL_WAKE_MASK 16'h0006
`define SEL_BH_RESET 16'h0007
`define SEL_FORCE_LPM 16'h0008
`define LINK_U3 8'h03
`define WMASK_CONN 0
`define WMASK_DISC 1
`define WMASK_OC 2
`define WMASK_USED 3
`define WMASK_RESET 3'h0
`define REG_CTRL 8'h00
`define REG_IRQ_STATUS 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_WAKE_MASK 8'h0C
`define REG_PORT_CHANGE 8'h10
`define IRQ_REQ_ERR 0
`define IRQ_WARM_DONE 1
`define IRQ_WAKE 2
`define IRQ_BITS 3
`define CHG_CONN_LSB 0
`define CHG_OC_LSB 4
`define CHG_WARM_LSB 8
`define CTRL_CONFIGURED 0
`endif

// *** core/hub_feature_pkg.sv ***
// Types for the downstream port set-feature handler
package hub_feature_pkg;
  typedef logic [2:0] wake_mask_t;
  typedef logic [3:0] port_vec_t;
  typedef logic [7:0] reg_addr_t;
  typedef enum logic [1:0] {HT_IDLE, HT_BUSY, HT_NONSEQ, HT_SEQ} htrans_t;
endpackage

// *** core/hub_port_set_feature_handler.sv ***
// Set Port Feature handler for the downstream ports of a hub
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module hub_port_set_feature_handler (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic req_valid_in,
  input wire logic [15:0] req_selector_in,
  input wire logic [15:0] req_index_in,
  input wire logic [15:0] req_length_in,
  output logic req_done_out,
  output logic req_stall_out,
  input hub_feature_pkg::port_vec_t port_powered_in,
  input hub_feature_pkg::port_vec_t port_enabled_in,
  input hub_feature_pkg::port_vec_t port_suspended_in,
  input hub_feature_pkg::port_vec_t connect_event_in,
  input hub_feature_pkg::port_vec_t disconnect_event_in,
  input hub_feature_pkg::port_vec_t oc_event_in,
  input wire logic hub_oc_event_in,
  input hub_feature_pkg::port_vec_t reset_done_in,
  output hub_feature_pkg::port_vec_t port_reset_start_out,
  output hub_feature_pkg::port_vec_t warm_reset_start_out,
  output hub_feature_pkg::port_vec_t reset_finish_out,
  output hub_feature_pkg::port_vec_t power_on_out,
  output hub_feature_pkg::port_vec_t u3_request_out,
  output hub_feature_pkg::port_vec_t force_lpm_out,
  output hub_feature_pkg::port_vec_t warm_change_out,
  output logic remote_wake_out,
  output logic irq_out
);
  import hub_feature_pkg::*;

  reg_addr_t rd_addr;
  reg_addr_t wr_addr;
  logic wr_en;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic configured;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  wake_mask_t wake_mask [`NPORTS];
  port_vec_t reset_active;
  port_vec_t warm_active;
  port_vec_t conn_change;
  port_vec_t oc_change;
  port_vec_t port_wake;
  logic hub_oc_wake;
  logic any_oc_enable;
  logic [7:0] port_num;
  logic [7:0] upper;
  logic port_ok;
  logic sel_ok;
  logic req_error;
  logic [1:0] port_idx;
  port_vec_t port_hit;
  logic wr_port_change;

  // Valid port numbers run from 1 up to the port count
  function automatic logic port_valid(input logic [7:0] num);
    port_valid = (num != 8'h00) && (num <= 8'(`NPORTS));
  endfunction

  // Defined port feature selectors
  function automatic logic selector_known(input logic [15:0] sel);
    case (sel)
      `SEL_PORT_RESET, `SEL_PORT_POWER, `SEL_LINK_STATE, `SEL_U1_TIMEOUT,
      `SEL_U2_TIMEOUT, `SEL_WAKE_MASK, `SEL_BH_RESET, `SEL_FORCE_LPM: selector_known = 1'b1;
      default: selector_known = 1'b0;
    endcase
  endfunction

  ahb_reg_port u_bus (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .rd_data_in(rd_data),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .rd_addr_out(rd_addr),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  // Request field decode
  assign port_num = req_index_in[7:0];
  assign upper = req_index_in[15:8];
  assign port_ok = port_valid(port_num);
  assign sel_ok = selector_known(req_selector_in);
  assign req_error = !configured || !sel_ok || !port_ok || (req_length_in != 16'h0000);
  assign port_idx = 2'(port_num - 8'h01);
  assign wr_port_change = wr_en && (wr_addr == `REG_PORT_CHANGE);

  generate
    for (genvar p = 0; p < `NPORTS; p++) begin : g_hit
      assign port_hit[p] = req_valid_in && !req_error && (port_idx == 2'(p));
    end
  endgenerate

  // Request answer, one cycle after the request
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_done_out <= 1'b0;
      req_stall_out <= 1'b0;
    end else begin
      req_done_out <= req_valid_in;
      if (req_valid_in) begin
        req_stall_out <= req_error;
      end
    end
  end

  // Per-port wake mask
  generate
    for (genvar p = 0; p < `NPORTS; p++) begin : g_mask
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          wake_mask[p] <= `WMASK_RESET;
        end else if (port_hit[p] && (req_selector_in == `SEL_WAKE_MASK)) begin
          wake_mask[p] <= upper[`WMASK_USED-1:0];
        end
      end
    end
  endgenerate

  // Per-port actions
  generate
    for (genvar p = 0; p < `NPORTS; p++) begin : g_act
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          port_reset_start_out[p] <= 1'b0;
          warm_reset_start_out[p] <= 1'b0;
          power_on_out[p] <= 1'b0;
          u3_request_out[p] <= 1'b0;
          force_lpm_out[p] <= 1'b0;
        end else begin
          port_reset_start_out[p] <= port_hit[p] && (req_selector_in == `SEL_PORT_RESET) &&
                                     port_powered_in[p];
          warm_reset_start_out[p] <= port_hit[p] && (req_selector_in == `SEL_BH_RESET);
          power_on_out[p] <= port_hit[p] && (req_selector_in == `SEL_PORT_POWER) &&
                             !port_powered_in[p];
          u3_request_out[p] <= port_hit[p] && (req_selector_in == `SEL_LINK_STATE) &&
                               (upper == `LINK_U3) && port_enabled_in[p];
          force_lpm_out[p] <= port_hit[p] && (req_selector_in == `SEL_FORCE_LPM) &&
                              port_enabled_in[p];
        end
      end
    end
  endgenerate

  // Reset tracking and completion
  generate
    for (genvar p = 0; p < `NPORTS; p++) begin : g_rst
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          reset_active[p] <= 1'b0;
          warm_active[p] <= 1'b0;
          reset_finish_out[p] <= 1'b0;
        end else begin
          reset_finish_out[p] <= reset_done_in[p] && (reset_active[p] || warm_active[p]);
          if (port_reset_start_out[p]) begin
            reset_active[p] <= 1'b1;
          end else if (reset_done_in[p]) begin
            reset_active[p] <= 1'b0;
          end
          if (warm_reset_start_out[p]) begin
            warm_active[p] <= 1'b1;
          end else if (reset_done_in[p]) begin
            warm_active[p] <= 1'b0;
          end
        end
      end
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          warm_change_out[p] <= 1'b0;
        end else if (reset_done_in[p] && warm_active[p]) begin
          warm_change_out[p] <= 1'b1;
        end else if (wr_port_change && wr_data[`CHG_WARM_LSB + p]) begin
          warm_change_out[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // Hub-wide over-current without per-port detection
  always_comb begin
    any_oc_enable = 1'b0;
    for (int p = 0; p < `NPORTS; p++) begin
      any_oc_enable = any_oc_enable | wake_mask[p][`WMASK_OC];
    end
  end
  assign hub_oc_wake = !`PER_PORT_OC && hub_oc_event_in && any_oc_enable && (|port_suspended_in);

  generate
    for (genvar p = 0; p < `NPORTS; p++) begin : g_wake
      port_wake_tracker u_track (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .mask_in(wake_mask[p]),
        .suspended_in(port_suspended_in[p]),
        .connect_in(connect_event_in[p]),
        .disconnect_in(disconnect_event_in[p]),
        .oc_in(oc_event_in[p] || (!`PER_PORT_OC && hub_oc_event_in)),
        .hub_oc_wake_in(hub_oc_wake),
        .clr_conn_in(wr_port_change && wr_data[`CHG_CONN_LSB + p]),
        .clr_oc_in(wr_port_change && wr_data[`CHG_OC_LSB + p]),
        .conn_change_out(conn_change[p]),
        .oc_change_out(oc_change[p]),
        .wake_out(port_wake[p])
      );
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remote_wake_out <= 1'b0;
    end else begin
      remote_wake_out <= |port_wake;
    end
  end

  // Control and interrupt mask registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      configured <= 1'b0;
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      if (wr_addr == `REG_CTRL) begin
        configured <= wr_data[`CTRL_CONFIGURED];
      end
      if (wr_addr == `REG_IRQ_MASK) begin
        irq_mask <= wr_data[`IRQ_BITS-1:0];
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_status <= 3'h0;
    end else begin
      for (int b = 0; b < `IRQ_BITS; b++) begin
        if (wr_en && (wr_addr == `REG_IRQ_STATUS) && wr_data[b]) begin
          irq_status[b] <= 1'b0;
        end
      end
      if (req_valid_in && req_error) begin
        irq_status[`IRQ_REQ_ERR] <= 1'b1;
      end
      if (|(reset_done_in & warm_active)) begin
        irq_status[`IRQ_WARM_DONE] <= 1'b1;
      end
      if (|port_wake) begin
        irq_status[`IRQ_WAKE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `REG_CTRL: rd_data[`CTRL_CONFIGURED] = configured;
      `REG_IRQ_STATUS: rd_data[`IRQ_BITS-1:0] = irq_status;
      `REG_IRQ_MASK: rd_data[`IRQ_BITS-1:0] = irq_mask;
      `REG_WAKE_MASK: begin
        for (int p = 0; p < `NPORTS; p++) begin
          rd_data[p*8 +: `WMASK_USED] = wake_mask[p];
        end
      end
      `REG_PORT_CHANGE: begin
        rd_data[`CHG_CONN_LSB +: `NPORTS] = conn_change;
        rd_data[`CHG_OC_LSB +: `NPORTS] = oc_change;
        rd_data[`CHG_WARM_LSB +: `NPORTS] = warm_change_out;
      end
      default: rd_data = 32'h00000000;
    endcase
  end
endmodule

// *** core/port_wake_tracker.sv ***
// Per-port change recording and remote wake qualification
`timescale 1ns/1ns
`include "hub_feature_params.svh"
module port_wake_tracker (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input hub_feature_pkg::wake_mask_t mask_in,
  input wire logic suspended_in,
  input wire logic connect_in,
  input wire logic disconnect_in,
  input wire logic oc_in,
  input wire logic hub_oc_wake_in,
  input wire logic clr_conn_in,
  input wire logic clr_oc_in,
  output logic conn_change_out,
  output logic oc_change_out,
  output logic wake_out
);
  import hub_feature_pkg::*;
  // Change flags are kept regardless of the mask; set wins over clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conn_change_out <= 1'b0;
      oc_change_out <= 1'b0;
    end else begin
      if (connect_in || disconnect_in) begin
        conn_change_out <= 1'b1;
      end else if (clr_conn_in) begin
        conn_change_out <= 1'b0;
      end
      if (oc_in) begin
        oc_change_out <= 1'b1;
      end else if (clr_oc_in) begin
        oc_change_out <= 1'b0;
      end
    end
  end
  // Wake request only while suspended, on a mask-enabled event or on hub_oc_wake_in
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= suspended_in && ((connect_in && mask_in[`WMASK_CONN]) ||
                  (disconnect_in && mask_in[`WMASK_DISC]) ||
                  (oc_in && mask_in[`WMASK_OC]) || hub_oc_wake_in);
    end
  end
endmodule
